// ### inc/pip_pkg.sv
// Package for the pulse-inhibit and point-table positioner.
// Assumes a single pclk domain at 20 MHz and APB register access.
package pip_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int NPOINT = 16;
	// Register byte offsets
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_SPD = 12'h004;
	localparam logic [11:0] OFS_DONE = 12'h008;
	localparam logic [11:0] OFS_STAT = 12'h00c;
	localparam logic [11:0] OFS_POS = 12'h010;
	localparam logic [11:0] OFS_ERR = 12'h014;
	localparam logic [11:0] OFS_PT_BASE = 12'h100;
	localparam logic [11:0] OFS_PT_END = 12'h200;
	// Control fields
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_ECLR_LSB = 4;
	localparam int CTL_STOP_LSB = 6;
	localparam int CTL_STEP_LSB = 8;
	localparam int CTL_CYC = 10;
	localparam int CTL_ABS = 11;
	localparam int CTL_HREV = 12;
	localparam int CTL_SON = 13;
	localparam int CTL_HOME = 14;
	localparam int CTL_START = 15;
	localparam logic [3:0] MODE_INHIBIT = 4'hb;
	localparam logic [3:0] MODE_POINT = 4'hc;
	localparam logic [1:0] ECLR_SOFF = 2'h0;
	localparam logic [1:0] ECLR_NEVER = 2'h1;
	localparam logic [1:0] ECLR_BOTH = 2'h2;
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	// Speed defaults, rpm
	localparam logic [11:0] SEEK_MAX = 12'd3000;
	localparam logic [11:0] SEEK_RST = 12'd1500;
	localparam logic [7:0] LEAVE_MAX = 8'd200;
	localparam logic [7:0] LEAVE_RST = 8'd30;
	// Done window pulses and settle time in 0.1 ms units
	localparam logic [15:0] WIN_RST = 16'd100;
	localparam logic [15:0] SETTLE_RST = 16'd500;
	localparam int TICK_US = 100;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	localparam logic [13:0] OFS_LIM = 14'd9999;
	localparam logic [13:0] COARSE_MUL = 14'd10000;
	typedef struct packed {
		// 15 bits: a 14-bit signed field cannot hold +-9999
		logic signed [14:0] coarse;
		logic signed [14:0] fine;
		logic [11:0] speed;
		logic [15:0] filt;
		logic [15:0] dwell;
	} pip_point_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_DWELL = 6'b000010,
		ST_MOVE = 6'b000100,
		ST_SEEK = 6'b001000,
		ST_LEAVE = 6'b010000,
		ST_INDEX = 6'b100000
	} pip_state_t;
endpackage

// ### rtl/pip_top.sv
// Position-control logic: pulse inhibit, 16-point table positioner, homing.
// Assumes pin inputs are asynchronous and APB master on pclk.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Inhibit stops reference pulse counting
// - Shaft held clamped while inhibited
// - Mode B switches by mode-switch input
// - Low mode-switch enables inhibit, high resumes
// - Mode C runs internal point table
// - Sixteen points with distance, speed, filter, dwell
// - Offset is coarse times 10000 plus fine
// - Absolute and relative coordinate modes
// - Cycling and single-run modes
// - Step by delay or mode-switch input
// - Point speed is actual motor speed
// - Point filter acts like common filter
// - Dwell timed from done, enable, home
// - Error clear by policy 0, 1, 2
// - Homing stops, reverses, zeroes on index
// - Seek speed 0..3000 rpm, default 1500
// - Leave speed 0..200 rpm, default 30
// - Limits not current limits during homing
// - Done when error small for settle time
// - Coordinate mode 0 incremental, 1 absolute
module pip_top
	import pip_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ref_pulse_in,
	input wire logic ref_dir_in,
	input wire logic mode_switch_input_n,
	input wire logic forward_limit_input_n,
	input wire logic reverse_limit_input_n,
	input wire logic encoder_index_in,
	input wire logic overtravel_in,
	input wire logic signed [31:0] feedback_pos,
	output logic signed [31:0] position_command,
	output logic [11:0] speed_command,
	output logic [15:0] filter_time,
	output logic motor_clamp,
	output logic current_limit_enable,
	output logic positioning_complete_output
);
	import pip_pkg::*;
	logic [31:0] ctrl_r;
	logic [11:0] seek_speed_r;
	logic [7:0] leave_speed_r;
	logic [15:0] done_window_r;
	logic [15:0] done_settle_time_r;
	pip_point_t table_r [NPOINT];
	logic [4:0] s1_r;
	logic [4:0] s2_r;
	logic [4:0] s3_r;
	logic [1:0] s4_r;
	logic [1:0] s5_r;
	logic signed [31:0] cmd_r;
	logic signed [31:0] origin_r;
	logic [3:0] pt_r;
	logic [15:0] dwell_r;
	logic [15:0] settle_r;
	logic [15:0] tick_r;
	logic done_r;
	logic done_prev_r;
	logic son_prev_r;
	pip_state_t st_r;
	logic [31:0] rdata_nxt;

	wire logic [3:0] mode = ctrl_r[CTL_MODE_LSB +: 4];
	wire logic [1:0] eclr = ctrl_r[CTL_ECLR_LSB +: 2];
	wire logic [1:0] step_m = ctrl_r[CTL_STEP_LSB +: 2];
	wire logic son = ctrl_r[CTL_SON];
	wire logic pcon = s2_r[0];
	wire logic pcon_prev = s3_r[0];
	wire logic fwd_hit = ~s2_r[1];
	wire logic rev_hit = ~s2_r[2];
	wire logic idx_rise = s2_r[3] & ~s3_r[3];
	wire logic pulse_rise = s2_r[4] & ~s3_r[4];
	wire logic inhibit = (mode == MODE_INHIBIT) && !pcon;
	wire logic wr = psel && penable && pwrite;
	wire logic homing = (st_r == ST_SEEK) || (st_r == ST_LEAVE) || (st_r == ST_INDEX);
	wire logic home_hit = ctrl_r[CTL_HREV] ? rev_hit : fwd_hit;
	wire logic signed [31:0] err = cmd_r - feedback_pos;
	wire logic [31:0] err_abs = err[31] ? 32'(-err) : 32'(err);
	wire logic err_clear = (!son && eclr != ECLR_NEVER)
		|| (s5_r[0] && eclr == ECLR_BOTH);
	wire pip_point_t cur = table_r[pt_r];
	// Sign-extend and combine split offsets
	wire logic signed [31:0] offs = 32'(cur.coarse) * $signed({18'h0, COARSE_MUL})
		+ 32'(cur.fine);
	wire logic step_evt = step_m[0] ? (pcon != pcon_prev) : (dwell_r == 16'h0);
	wire logic tick = tick_r == 16'(TICK_CYC - 1);

	// Two-flop synchronisers for pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_r <= 5'h1f;
			s2_r <= 5'h1f;
			s3_r <= 5'h1f;
			s4_r <= 2'h0;
			s5_r <= 2'h0;
		end
		else
		begin
			s1_r <= {ref_pulse_in, encoder_index_in, reverse_limit_input_n,
				forward_limit_input_n, mode_switch_input_n};
			s2_r <= s1_r;
			s3_r <= s2_r;
			// Level pins: direction and overtravel
			s4_r <= {ref_dir_in, overtravel_in};
			s5_r <= s4_r;
		end
	end

	// APB register writes; speeds are clamped to their legal range
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r <= CTRL_RST;
			seek_speed_r <= SEEK_RST;
			leave_speed_r <= LEAVE_RST;
			done_window_r <= WIN_RST;
			done_settle_time_r <= SETTLE_RST;
		end
		else if (wr)
		begin
			unique case (paddr)
				OFS_CTRL: ctrl_r <= pwdata;
				OFS_SPD:
				begin
					seek_speed_r <= (pwdata[11:0] > SEEK_MAX) ? SEEK_MAX : pwdata[11:0];
					leave_speed_r <= (pwdata[23:16] > LEAVE_MAX) ? LEAVE_MAX
						: pwdata[23:16];
				end
				OFS_DONE:
				begin
					done_window_r <= pwdata[15:0];
					done_settle_time_r <= pwdata[31:16];
				end
				default: ;
			endcase
		end
		else if (ctrl_r[CTL_START] || ctrl_r[CTL_HOME])
		begin
			// Start and home bits are self-clearing commands
			ctrl_r[CTL_START] <= 1'b0;
			ctrl_r[CTL_HOME] <= 1'b0;
		end
	end

	// Point table: three words per point, out-of-range offset fields saturate
	genvar gi;
	generate
		for (gi = 0; gi < NPOINT; gi++)
		begin : g_pt
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					table_r[gi] <= '0;
				else if (wr && paddr[11:8] == OFS_PT_BASE[11:8] && paddr[7:4] == 4'(gi))
				begin
					if (paddr[3:2] == 2'h0)
					begin
						table_r[gi].coarse <= sat(pwdata[15:0]);
						table_r[gi].fine <= sat(pwdata[31:16]);
					end
					else if (paddr[3:2] == 2'h1)
					begin
						table_r[gi].speed <= pwdata[11:0];
						table_r[gi].filt <= pwdata[31:16];
					end
					else if (paddr[3:2] == 2'h2)
						table_r[gi].dwell <= pwdata[15:0];
				end
			end
		end
	endgenerate

	function automatic logic signed [14:0] sat(input logic [15:0] v);
		logic signed [15:0] s;
		s = $signed(v);
		if (s > $signed({2'b0, OFS_LIM}))
			sat = $signed({1'b0, OFS_LIM});
		else if (s < -$signed({2'b0, OFS_LIM}))
			sat = -$signed({1'b0, OFS_LIM});
		else
			sat = s[14:0];
	endfunction

	// 0.1 ms time base
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_r <= 16'h0;
		else
			tick_r <= tick ? 16'h0 : tick_r + 16'h1;
	end

	// Positioning done: error inside window for longer than settle time
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			settle_r <= 16'h0;
			done_r <= 1'b0;
			done_prev_r <= 1'b0;
			son_prev_r <= 1'b0;
		end
		else
		begin
			done_prev_r <= done_r;
			son_prev_r <= son;
			if (err_abs >= {16'h0, done_window_r})
				settle_r <= 16'h0;
			else if (tick && settle_r != 16'hffff)
				settle_r <= settle_r + 16'h1;
			done_r <= (err_abs < {16'h0, done_window_r})
				&& (settle_r > done_settle_time_r);
		end
	end

	// Command count, point sequencer and homing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_r <= 32'sh0;
			origin_r <= 32'sh0;
			pt_r <= 4'h0;
			dwell_r <= 16'h0;
			st_r <= ST_IDLE;
		end
		else if (err_clear)
		begin
			cmd_r <= feedback_pos;
			st_r <= ST_IDLE;
		end
		else if (mode == MODE_POINT)
		begin
			if (dwell_r != 16'h0 && tick)
				dwell_r <= dwell_r - 16'h1;
			unique case (st_r)
				ST_IDLE:
				begin
					if (ctrl_r[CTL_HOME])
						st_r <= ST_SEEK;
					else if (ctrl_r[CTL_START] || (son && !son_prev_r))
					begin
						pt_r <= 4'h0;
						dwell_r <= table_r[0].dwell;
						st_r <= ST_DWELL;
					end
				end
				ST_DWELL:
					if (step_evt)
					begin
						cmd_r <= ctrl_r[CTL_ABS] ? origin_r + offs : cmd_r + offs;
						st_r <= ST_MOVE;
					end
				ST_MOVE:
					if (done_r && !done_prev_r)
					begin
						if (pt_r != 4'(NPOINT - 1))
						begin
							pt_r <= pt_r + 4'h1;
							dwell_r <= table_r[pt_r + 4'h1].dwell;
							st_r <= ST_DWELL;
						end
						else if (ctrl_r[CTL_CYC])
						begin
							pt_r <= 4'h0;
							dwell_r <= table_r[0].dwell;
							st_r <= ST_DWELL;
						end
						else
							st_r <= ST_IDLE;
					end
				ST_SEEK:
					if (home_hit)
					begin
						cmd_r <= feedback_pos;
						st_r <= ST_LEAVE;
					end
				ST_LEAVE:
					if (!home_hit)
						st_r <= ST_INDEX;
				ST_INDEX:
					if (idx_rise)
					begin
						origin_r <= feedback_pos;
						cmd_r <= feedback_pos;
						pt_r <= 4'h0;
						dwell_r <= table_r[0].dwell;
						st_r <= ST_DWELL;
					end
				default: st_r <= ST_IDLE;
			endcase
		end
		else
		begin
			st_r <= ST_IDLE;
			if (pulse_rise && !inhibit)
				cmd_r <= s5_r[1] ? cmd_r - 32'sh1 : cmd_r + 32'sh1;
		end
	end

	always_comb
	begin
		rdata_nxt = 32'h0;
		unique case (paddr)
			OFS_CTRL: rdata_nxt = ctrl_r;
			OFS_SPD: rdata_nxt = {8'h0, leave_speed_r, 4'h0, seek_speed_r};
			OFS_DONE: rdata_nxt = {done_settle_time_r, done_window_r};
			OFS_STAT: rdata_nxt = {16'h0, 10'h0, st_r};
			OFS_POS: rdata_nxt = cmd_r - origin_r;
			OFS_ERR: rdata_nxt = err;
			default:
				if (paddr[11:8] == OFS_PT_BASE[11:8])
					rdata_nxt = point_word(table_r[paddr[7:4]], paddr[3:2]);
		endcase
	end

	function automatic logic [31:0] point_word(input pip_point_t p, input logic [1:0] w);
		if (w == 2'h0)
			point_word = {p.fine[14], p.fine, p.coarse[14], p.coarse};
		else if (w == 2'h1)
			point_word = {p.filt, 4'h0, p.speed};
		else if (w == 2'h2)
			point_word = {16'h0, p.dwell};
		else
			point_word = 32'h0;
	endfunction

	// APB answer, zero wait; outputs registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			position_command <= 32'sh0;
			speed_command <= 12'h0;
			filter_time <= 16'h0;
			motor_clamp <= 1'b0;
			current_limit_enable <= 1'b0;
			positioning_complete_output <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			prdata <= rdata_nxt;
			pslverr <= psel && !penable && !(paddr < OFS_ERR + 12'h4
				|| (paddr >= OFS_PT_BASE && paddr < OFS_PT_END));
			position_command <= cmd_r;
			speed_command <= (st_r == ST_SEEK) ? seek_speed_r
				: (st_r == ST_LEAVE || st_r == ST_INDEX) ? {4'h0, leave_speed_r}
				: (mode == MODE_POINT) ? cur.speed : 12'h0;
			filter_time <= (mode == MODE_POINT) ? cur.filt : 16'h0;
			motor_clamp <= inhibit || (st_r == ST_SEEK && home_hit);
			current_limit_enable <= !homing && (fwd_hit || rev_hit);
			positioning_complete_output <= done_r;
		end
	end
endmodule
`default_nettype wire

// ### tb/pip_sva.sv
// Port checker for pip_top.
// Assumes a bind onto pip_top; one pclk domain.
`timescale 1ns/1ps
`default_nettype none
module pip_sva
	import pip_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [31:0] feedback_pos,
	input wire logic signed [31:0] position_command,
	input wire logic [11:0] speed_command,
	input wire logic motor_clamp,
	input wire logic positioning_complete_output
);
	logic signed [31:0] perr;
	assign perr = position_command - feedback_pos;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	apb_answer_a: assert property (s_setup |=> s_answer)
		else $error("access phase not answered");
	ready_one_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	ready_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	slverr_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// Four cycles covers the pin synchroniser, so a late pulse cannot count
	clamp_hold_a: assert property (motor_clamp && $past(motor_clamp, 4) |-> $stable(position_command))
		else $error("command moved while clamped");
	done_bound_a: assert property (positioning_complete_output |-> perr < 65536 && perr > -65536)
		else $error("done with large error");
	reset_out_a: assert property ($rose(presetn) |-> !motor_clamp && position_command == 0)
		else $error("outputs not cleared by reset");
	done_rise_a: assert property ($rose(positioning_complete_output) |-> $past(perr) < 65536)
		else $error("done rose with large error");
endmodule
`default_nettype wire

// ### tb/pip_host_model.sv
// Host pulse source, mode switch, forward limit switch and index for pip_top.
// Assumes pclk from the bench; switch lines idle high by pull-up.
`timescale 1ns/1ps
`default_nettype none
module pip_host_model (
	input wire logic pclk,
	output logic ref_pulse,
	output logic ref_dir,
	output logic mode_sw_n,
	output logic fwd_lim_n,
	output logic index
);
	initial
	begin
		ref_pulse = 0;
		ref_dir = 0;
		mode_sw_n = 1;
		fwd_lim_n = 1;
		index = 0;
	end
	// Pulses long enough for the two-flop synchroniser
	task automatic pulses(input int n);
		repeat (n)
		begin
			@(posedge pclk);
			ref_pulse <= 1;
			repeat (4) @(posedge pclk);
			ref_pulse <= 0;
			repeat (4) @(posedge pclk);
		end
	endtask
	task automatic set_dir(input logic v);
		@(posedge pclk);
		ref_dir <= v;
		repeat (4) @(posedge pclk);
	endtask
	task automatic set_switch(input logic v);
		@(posedge pclk);
		mode_sw_n <= v;
		repeat (6) @(posedge pclk);
	endtask
	// Forward homing uses the forward limit line only
	task automatic set_limit(input logic v);
		@(posedge pclk);
		fwd_lim_n <= v;
		repeat (6) @(posedge pclk);
	endtask
	task automatic index_pulse;
		@(posedge pclk);
		index <= 1;
		repeat (4) @(posedge pclk);
		index <= 0;
	endtask
endmodule
`default_nettype wire

// ### tb/pip_top_test.sv
// Self-checking bench for pip_top with host model and checker.
// Assumes pclk 20 MHz; registers reached over APB.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module pip_top_test;
	import pip_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr, speed_command;
	logic [31:0] pwdata, prdata, rd;
	logic err, ref_pulse, ref_dir, sw_n, fwd_n, rev_n, index, overtravel;
	logic motor_clamp, current_limit_enable, done;
	logic signed [31:0] feedback_pos, position_command, p0;
	logic [15:0] filter_time;
	int error_cnt = 0;
	int checked = 0;
	pip_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ref_pulse_in(ref_pulse), .ref_dir_in(ref_dir),
		.mode_switch_input_n(sw_n), .forward_limit_input_n(fwd_n),
		.reverse_limit_input_n(rev_n), .encoder_index_in(index), .overtravel_in(overtravel),
		.feedback_pos(feedback_pos), .position_command(position_command),
		.speed_command(speed_command), .filter_time(filter_time), .motor_clamp(motor_clamp),
		.current_limit_enable(current_limit_enable), .positioning_complete_output(done));
	pip_host_model i_host (.pclk(pclk), .ref_pulse(ref_pulse), .ref_dir(ref_dir),
		.mode_sw_n(sw_n), .fwd_lim_n(fwd_n), .index(index));
	initial
	begin
		pclk = 0;
		forever #25 pclk = ~pclk;
	end
	task stop_test;
		$display("checked=%0d error_cnt=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20)
		begin
			error_cnt++;
			stop_test();
		end
		@(posedge pclk);
	endtask
	task automatic wait_state(input logic [5:0] s);
		int n;
		n = 0;
		do
		begin
			apb(0, OFS_STAT, 0);
			n++;
		end
		while (rd[5:0] !== s && n < 300);
		`CHK(rd[5:0], s)
	endtask
	task t_regs;
		apb(0, OFS_CTRL, 0);
		`CHK(rd, CTRL_RST)
		apb(0, OFS_SPD, 0);
		`CHK(rd, {8'h00, LEAVE_RST, 4'h0, SEEK_RST})
		apb(0, OFS_DONE, 0);
		`CHK(rd, {SETTLE_RST, WIN_RST})
		apb(1, OFS_SPD, 32'hffffffff);
		apb(0, OFS_SPD, 0);
		`CHK(rd & 32'h00ff0fff, {8'h00, LEAVE_MAX, 4'h0, SEEK_MAX})
		apb(1, OFS_SPD, {8'h00, LEAVE_RST, 4'h0, SEEK_RST});
		apb(0, 12'h018, 0);
		`CHK(err, 1'b1)
		$display("t_regs done");
	endtask
	// Saturation at the field limits and all sixteen dwell words
	task t_points;
		apb(1, OFS_PT_BASE, 32'hd1202ee0);
		apb(0, OFS_PT_BASE, 0);
		`CHK(rd, 32'hd8f1270f)
		for (int n = 0; n < NPOINT; n++)
			apb(1, OFS_PT_BASE + 12'(16 * n + 8), 32'(n + 1));
		for (int n = 0; n < NPOINT; n++)
		begin
			apb(0, OFS_PT_BASE + 12'(16 * n + 8), 0);
			`CHK(rd[15:0], 16'(n + 1))
		end
		$display("t_points done");
	endtask
	task t_inhibit;
		apb(1, OFS_CTRL, 32'h0000200b);
		i_host.set_switch(0);
		p0 = position_command;
		i_host.pulses(5);
		`CHK(position_command, p0)
		`CHK(motor_clamp, 1'b1)
		i_host.set_switch(1);
		i_host.pulses(5);
		`CHK(position_command, p0 + 32'sd5)
		i_host.set_dir(1);
		i_host.pulses(1);
		`CHK(position_command, p0 + 32'sd4)
		i_host.set_dir(0);
		apb(1, OFS_CTRL, 32'h0000001b);
		apb(1, OFS_CTRL, 32'h0000201b);
		i_host.pulses(2);
		apb(1, OFS_CTRL, 32'h0000001b);
		`CHK(position_command, p0 + 32'sd6)
		apb(1, OFS_CTRL, 32'h0000202b);
		feedback_pos <= 32'sd5678;
		overtravel <= 1;
		repeat (6) @(posedge pclk);
		`CHK(position_command, 32'sd5678)
		overtravel <= 0;
		feedback_pos <= 32'sd1234;
		apb(1, OFS_CTRL, 32'h0000000b);
		repeat (2) @(posedge pclk);
		`CHK(position_command, 32'sd1234)
		rev_n <= 0;
		repeat (5) @(posedge pclk);
		`CHK(current_limit_enable, 1'b1)
		rev_n <= 1;
		repeat (5) @(posedge pclk);
		$display("t_inhibit done");
	endtask
	task t_home;
		// Longer dwell keeps point 0 parked while the position is read
		apb(1, OFS_PT_BASE + 12'h008, 32'h00000003);
		apb(1, OFS_CTRL, 32'h0000600c);
		wait_state(6'h08);
		`CHK(speed_command, SEEK_RST)
		`CHK(current_limit_enable, 1'b0)
		i_host.set_limit(0);
		wait_state(6'h10);
		`CHK(speed_command, 12'(LEAVE_RST))
		i_host.set_limit(1);
		wait_state(6'h20);
		i_host.index_pulse();
		wait_state(6'h02);
		apb(0, OFS_POS, 0);
		`CHK(rd, 32'h00000000)
		$display("t_home done");
	endtask
	initial
	begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		overtravel = 0;
		rev_n = 1;
		feedback_pos = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		t_regs();
		t_points();
		t_inhibit();
		t_home();
		stop_test();
	end
endmodule
bind pip_top pip_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .feedback_pos(feedback_pos),
	.position_command(position_command), .speed_command(speed_command),
	.motor_clamp(motor_clamp), .positioning_complete_output(positioning_complete_output));
`default_nettype wire
